//--- hw/haptic_pkg.sv
// Constants, types and shared arithmetic for the haptic duty-to-drive block.
// Assumes a single 250 MHz system clock; all times below are turned into cycles here.
`default_nettype none

package haptic_pkg;

   localparam int CLK_HZ          = 250_000_000;
   localparam int CLK_MHZ         = 250;

   localparam int START_TIME_US   = 1300;
   localparam int START_CYC       = START_TIME_US * CLK_MHZ;

   localparam int CARRIER_HZ      = 20_300;
   localparam int CARRIER_CYC     = CLK_HZ / CARRIER_HZ;

   localparam int PWM_MIN_HZ      = 10_000;
   // Two slowest periods without an edge mean a steady 0% or 100% input
   localparam int PWM_TIMEOUT_CYC = 2 * (CLK_HZ / PWM_MIN_HZ);

   localparam int RES_MIN_HZ      = 140;
   localparam int RES_MAX_HZ      = 220;
   localparam int HALF_MIN_CYC    = (CLK_HZ + 2 * RES_MAX_HZ - 1) / (2 * RES_MAX_HZ);
   localparam int HALF_MAX_CYC    = CLK_HZ / (2 * RES_MIN_HZ);
   localparam int TIMER_W         = 20;

   localparam int SUPPLY_LSB_MV   = 25;
   localparam int ROT_FS_MV       = 3600;
   localparam int LIN_FS_MV       = 2200;
   localparam logic [7:0] ROT_FS_CODE = 8'(ROT_FS_MV / SUPPLY_LSB_MV);
   localparam logic [7:0] LIN_FS_CODE = 8'(LIN_FS_MV / SUPPLY_LSB_MV);

   localparam logic [7:0] DUTY_HALF = 8'h80;
   localparam logic [7:0] DUTY_FULL = 8'hff;
   localparam logic [7:0] DUTY_RST  = 8'h00;
   localparam logic [7:0] AMP_STEP  = 8'h08;
   localparam logic [7:0] BEMF_STOP = 8'h04;

   localparam int SYNC_EN   = 0;
   localparam int SYNC_PWM  = 1;
   localparam int SYNC_TYPE = 2;
   localparam int SYNC_BEMF = 3;

   typedef enum logic [1:0] {DRV_OFF, DRV_START, DRV_DRIVE} drive_state_t;

   // Duty above half, doubled: 0x80 -> 0, 0xff -> 0xfe
   function automatic logic [7:0] above_half(input logic [7:0] d);
      logic [7:0] t;
      t = d - DUTY_HALF;
      return (d > DUTY_HALF) ? {t[6:0], 1'b0} : 8'h00;
   endfunction

   // Duty below half, doubled and clamped: 0x00 -> 0xff
   function automatic logic [7:0] below_half(input logic [7:0] d);
      logic [7:0] t;
      t = DUTY_HALF - d;
      if (d == 8'h00)
         return 8'hff;
      return (d < DUTY_HALF) ? {t[6:0], 1'b0} : 8'h00;
   endfunction

   // One restoring-division step: {quotient bit, new remainder}
   function automatic logic [24:0] div_step(input logic [23:0] rem, input logic nb,
                                            input logic [23:0] den);
      logic [24:0] sh;
      logic [24:0] t;
      sh = {rem, nb};
      t  = sh - {1'b0, den};
      return (sh >= {1'b0, den}) ? {1'b1, t[23:0]} : {1'b0, sh[23:0]};
   endfunction

endpackage

`default_nettype wire

//--- hw/duty_meter.sv
// Measures the duty cycle of the synchronised host PWM, one result per period.
// Assumes pwm_level is already synchronised to sys_clk.
`default_nettype none

module duty_meter #(
   parameter int unsigned TIMEOUT_CYC = haptic_pkg::PWM_TIMEOUT_CYC,
   parameter int          CW          = 16
) (
   // Clock and reset
   input  wire logic          sys_clk,
   input  wire logic          rst,
   // Input
   input  wire logic          pwm_level,
   input  wire logic          clear,
   // Result
   output logic [7:0]         duty,
   output logic               duty_valid
);

   if (TIMEOUT_CYC < 2 || TIMEOUT_CYC >= 2 ** CW || CW > 16) begin : g_bad
      $error("duty_meter: timeout does not fit the counters");
   end

   localparam logic [CW-1:0] TMO = CW'(TIMEOUT_CYC - 1);

   logic          prev_reg;
   logic          seen_reg;
   logic [CW-1:0] per_cnt_reg;
   logic [CW-1:0] hi_cnt_reg;
   logic          busy_reg;
   logic [4:0]    step_reg;
   logic [23:0]   num_reg;
   logic [23:0]   den_reg;
   logic [23:0]   rem_reg;
   logic [23:0]   quot_reg;
   logic [24:0]   step_res;
   wire           rise    = pwm_level & ~prev_reg;
   wire           timeout = per_cnt_reg == TMO;

   assign step_res = haptic_pkg::div_step(rem_reg, num_reg[23], den_reg);

   // Rising edge closes a period: high time over period, alike for any period from 25 cycles to TIMEOUT_CYC - 1
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prev_reg    <= 1'b0;
         seen_reg    <= 1'b0;
         per_cnt_reg <= '0;
         hi_cnt_reg  <= '0;
         busy_reg    <= 1'b0;
         step_reg    <= 5'h00;
         num_reg     <= 24'h000000;
         den_reg     <= 24'h000000;
         rem_reg     <= 24'h000000;
         quot_reg    <= 24'h000000;
         duty        <= haptic_pkg::DUTY_RST;
         duty_valid  <= 1'b0;
      end else begin
         prev_reg   <= pwm_level;
         duty_valid <= 1'b0;
         if (clear) begin
            seen_reg    <= 1'b0;
            per_cnt_reg <= '0;
            hi_cnt_reg  <= '0;
            busy_reg    <= 1'b0;
         end else if (rise || timeout) begin
            seen_reg    <= rise;
            per_cnt_reg <= '0;
            // Rising cycle is itself high time
            hi_cnt_reg  <= CW'(rise);
            if (timeout) begin
               duty       <= pwm_level ? haptic_pkg::DUTY_FULL : 8'h00;
               duty_valid <= 1'b1;
            end else if (seen_reg) begin
               busy_reg <= 1'b1;
               step_reg <= 5'h17;
               num_reg  <= 24'({hi_cnt_reg, 8'h00});
               den_reg  <= 24'(per_cnt_reg) + 24'h000001;
               rem_reg  <= 24'h000000;
            end
         end else begin
            per_cnt_reg <= per_cnt_reg + 1'b1;
            if (pwm_level)
               hi_cnt_reg <= hi_cnt_reg + 1'b1;
         end
         if (busy_reg && !clear) begin
            rem_reg  <= step_res[23:0];
            num_reg  <= {num_reg[22:0], 1'b0};
            quot_reg <= {quot_reg[22:0], step_res[24]};
            step_reg <= step_reg - 1'b1;
            if (step_reg == 5'h00)
               busy_reg <= 1'b0;
         end
         if (busy_reg && step_reg == 5'h00 && !clear) begin
            duty       <= (quot_reg[22:7] != 16'h0000) ? 8'hff : {quot_reg[6:0], step_res[24]};
            duty_valid <= 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

//--- hw/carrier_pwm.sv
// Fixed-rate output carrier whose on-time is the magnitude scaled by supply.
// Assumes supply_code comes from a converter clocked on sys_clk.
`default_nettype none

module carrier_pwm #(
   parameter int unsigned PERIOD_CYC = haptic_pkg::CARRIER_CYC,
   parameter int          CW         = 16
) (
   // Clock and reset
   input  wire logic          sys_clk,
   input  wire logic          rst,
   // Control
   input  wire logic          active,
   input  wire logic [7:0]    mag,
   input  wire logic [7:0]    full_code,
   input  wire logic [7:0]    supply_code,
   // Carrier
   output logic               pulse_on
);

   if (PERIOD_CYC < 32 || PERIOD_CYC >= 2 ** CW || CW > 16) begin : g_bad
      $error("carrier_pwm: period does not fit the counter");
   end

   localparam logic [CW-1:0] LAST = CW'(PERIOD_CYC - 1);
   localparam logic [15:0]   PER  = 16'(PERIOD_CYC);

   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] on_reg;
   logic [4:0]    step_reg;
   logic          busy_reg;
   logic [23:0]   num_reg;
   logic [23:0]   rem_reg;
   logic [23:0]   quot_reg;
   logic [24:0]   step_res;
   logic [7:0]    ratio;
   logic [23:0]   on_prod;
   logic [15:0]   mag_prod;

   assign step_res = haptic_pkg::div_step(rem_reg, num_reg[23], {16'h0000, supply_code});
   assign ratio    = (quot_reg[22:7] != 16'h0000) ? 8'hff : {quot_reg[6:0], step_res[24]};
   assign on_prod  = ratio * PER;
   assign mag_prod = mag * full_code;

   // Magnitude taken at the end of a period; its on-time is worked out over the next 24 cycles and applied from then
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_reg  <= '0;
         on_reg   <= '0;
         step_reg <= 5'h00;
         busy_reg <= 1'b0;
         num_reg  <= 24'h000000;
         rem_reg  <= 24'h000000;
         quot_reg <= 24'h000000;
         pulse_on <= 1'b0;
      end else begin
         cnt_reg  <= (cnt_reg == LAST || !active) ? '0 : cnt_reg + 1'b1;
         pulse_on <= active && cnt_reg < on_reg;
         if (cnt_reg == LAST || !active) begin
            busy_reg <= active;
            step_reg <= 5'h17;
            num_reg  <= {8'h00, mag_prod};
            rem_reg  <= 24'h000000;
         end else if (busy_reg) begin
            rem_reg  <= step_res[23:0];
            num_reg  <= {num_reg[22:0], 1'b0};
            quot_reg <= {quot_reg[22:0], step_res[24]};
            step_reg <= step_reg - 1'b1;
            if (step_reg == 5'h00) begin
               busy_reg <= 1'b0;
               on_reg   <= CW'(on_prod[23:8]);
            end
         end
         if (!active)
            on_reg <= '0;
      end
   end

endmodule

`default_nettype wire

//--- hw/haptic_duty_to_drive_control.sv
// Top of the haptic driver control: duty meter, start-up, modes, resonance loop, outputs.
// Assumes enable, PWM, type select and back-EMF polarity are asynchronous pins;
// supply_code and bemf_level come from converters on sys_clk.
`default_nettype none

module haptic_duty_to_drive_control #(
   parameter int unsigned START_CYC   = haptic_pkg::START_CYC,
   parameter int unsigned CARRIER_CYC = haptic_pkg::CARRIER_CYC,
   parameter int unsigned PWM_TIMEOUT = haptic_pkg::PWM_TIMEOUT_CYC,
   parameter int unsigned HALF_MIN    = haptic_pkg::HALF_MIN_CYC,
   parameter int unsigned HALF_MAX    = haptic_pkg::HALF_MAX_CYC
) (
   // Clock and reset
   input  wire logic          sys_clk,
   input  wire logic          rst,
   // Host pins
   input  wire logic          drive_enable,
   input  wire logic          duty_pwm,
   input  wire logic          actuator_type_select,
   // Sensing
   input  wire logic [7:0]    supply_code,
   input  wire logic          bemf_polarity,
   input  wire logic [7:0]    bemf_level,
   // Differential output stage
   output logic               out_pos,
   output logic               out_pos_oe,
   output logic               out_neg,
   output logic               out_neg_oe,
   output logic               drive_active
);

   localparam int TW = haptic_pkg::TIMER_W;

   if (START_CYC < 2 || START_CYC >= 2 ** TW || HALF_MIN < 2 || HALF_MIN >= HALF_MAX
       || HALF_MAX >= 2 ** TW) begin : g_bad
      $error("haptic_duty_to_drive_control: timing parameters out of range");
   end

   localparam logic [TW-1:0] START_LAST = TW'(START_CYC - 1);
   localparam logic [TW-1:0] HALF_LO    = TW'(HALF_MIN - 1);
   localparam logic [TW-1:0] HALF_HI    = TW'(HALF_MAX - 1);

   // Pin synchronisers
   logic [3:0] meta_reg;
   logic [3:0] sync_reg;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta_reg <= 4'h0;
         sync_reg <= 4'h0;
      end else begin
         meta_reg <= {bemf_polarity, actuator_type_select, duty_pwm, drive_enable};
         sync_reg <= meta_reg;
      end
   end

   wire en_s   = sync_reg[haptic_pkg::SYNC_EN];
   wire pwm_s  = sync_reg[haptic_pkg::SYNC_PWM];
   wire type_s = sync_reg[haptic_pkg::SYNC_TYPE];
   wire bemf_s = sync_reg[haptic_pkg::SYNC_BEMF];

   // Duty measurement
   logic [7:0] duty;
   logic       duty_valid;

   duty_meter #(
      .TIMEOUT_CYC (PWM_TIMEOUT),
      .CW          (16)
   ) u_meter (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .pwm_level  (pwm_s),
      .clear      (~en_s),
      .duty       (duty),
      .duty_valid (duty_valid)
   );

   logic [7:0] cmd_reg;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         cmd_reg <= haptic_pkg::DUTY_RST;
      else if (!en_s)
         cmd_reg <= haptic_pkg::DUTY_RST;
      else if (duty_valid)
         cmd_reg <= duty;
   end

   // Start-up sequencing
   haptic_pkg::drive_state_t state_reg;
   haptic_pkg::drive_state_t state_next;
   logic [TW-1:0]            start_cnt_reg;
   logic                     mode_lin_reg;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         haptic_pkg::DRV_OFF:
            if (en_s)
               state_next = haptic_pkg::DRV_START;
         haptic_pkg::DRV_START:
            if (!en_s)
               state_next = haptic_pkg::DRV_OFF;
            else if (start_cnt_reg == START_LAST)
               state_next = haptic_pkg::DRV_DRIVE;
         haptic_pkg::DRV_DRIVE:
            if (!en_s)
               state_next = haptic_pkg::DRV_OFF;
         default:
            state_next = haptic_pkg::DRV_OFF;
      endcase
   end

   // Mode is sampled once per enable, as the pin is meant to be static
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg     <= haptic_pkg::DRV_OFF;
         start_cnt_reg <= '0;
         mode_lin_reg  <= 1'b0;
      end else begin
         state_reg     <= state_next;
         start_cnt_reg <= (state_reg == haptic_pkg::DRV_START) ? start_cnt_reg + 1'b1 : '0;
         if (state_reg == haptic_pkg::DRV_OFF && en_s)
            mode_lin_reg <= type_s;
      end
   end

   wire driving = state_reg == haptic_pkg::DRV_DRIVE;

   // Duty to strength: linear uses duty above half only, rotating is signed about half
   wire [7:0] lin_target = haptic_pkg::above_half(cmd_reg);
   wire       rot_fwd    = cmd_reg >= haptic_pkg::DUTY_HALF;
   wire [7:0] rot_mag    = rot_fwd ? haptic_pkg::above_half(cmd_reg)
                                   : haptic_pkg::below_half(cmd_reg);

   // Resonance tracking from back-EMF zero crossings
   logic          bemf_prev_reg;
   logic [TW-1:0] half_cnt_reg;
   logic          phase_reg;
   logic [7:0]    amp_reg;
   logic          brake_reg;

   wire       lin_on   = driving && mode_lin_reg;
   wire       xcross   = bemf_s ^ bemf_prev_reg;
   // Crossings faster than 220 Hz are noise; none by 140 Hz forces a flip
   wire       commute  = lin_on && ((xcross && half_cnt_reg >= HALF_LO) ||
                                     half_cnt_reg >= HALF_HI);
   wire       moving   = bemf_level > haptic_pkg::BEMF_STOP;
   wire [8:0] amp_sum  = {1'b0, amp_reg} + {1'b0, haptic_pkg::AMP_STEP};
   wire [7:0] amp_up   = amp_sum[8] ? 8'hff : amp_sum[7:0];

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bemf_prev_reg <= 1'b0;
         half_cnt_reg  <= '0;
         phase_reg     <= 1'b0;
      end else begin
         bemf_prev_reg <= bemf_s;
         if (!lin_on) begin
            half_cnt_reg <= '0;
            phase_reg    <= 1'b0;
         end else if (commute) begin
            half_cnt_reg <= '0;
            phase_reg    <= ~phase_reg;
         end else begin
            half_cnt_reg <= half_cnt_reg + 1'b1;
         end
      end
   end

   // Amplitude loop, evaluated once per half cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         amp_reg   <= 8'h00;
         brake_reg <= 1'b0;
      end else if (!lin_on) begin
         amp_reg   <= 8'h00;
         brake_reg <= 1'b0;
      end else if (commute) begin
         if (lin_target == 8'h00) begin
            brake_reg <= moving;
            amp_reg   <= 8'h00;
         end else if (bemf_level < lin_target) begin
            brake_reg <= 1'b0;
            amp_reg   <= amp_up;
         end else if (bemf_level > lin_target) begin
            brake_reg <= 1'b1;
         end else begin
            brake_reg <= 1'b0;
         end
      end
   end

   // Braking pushes against the motion with strength matching the back-EMF
   wire [7:0] lin_mag  = brake_reg ? bemf_level : amp_reg;
   wire       lin_pos  = phase_reg ^ brake_reg;
   wire [7:0] mag_sel  = mode_lin_reg ? lin_mag : rot_mag;
   wire       pos_sel  = mode_lin_reg ? lin_pos : rot_fwd;
   wire [7:0] fs_code  = mode_lin_reg ? haptic_pkg::LIN_FS_CODE : haptic_pkg::ROT_FS_CODE;

   logic pulse_on;

   carrier_pwm #(
      .PERIOD_CYC (CARRIER_CYC),
      .CW         (16)
   ) u_carrier (
      .sys_clk     (sys_clk),
      .rst         (rst),
      .active      (driving),
      .mag         (mag_sel),
      .full_code   (fs_code),
      .supply_code (supply_code),
      .pulse_on    (pulse_on)
   );

   // Output stage: the idle half is held low, both released in shutdown
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         out_pos      <= 1'b0;
         out_neg      <= 1'b0;
         out_pos_oe   <= 1'b0;
         out_neg_oe   <= 1'b0;
         drive_active <= 1'b0;
      end else begin
         out_pos      <= driving && en_s && pulse_on && pos_sel;
         out_neg      <= driving && en_s && pulse_on && !pos_sel;
         out_pos_oe   <= driving && en_s;
         out_neg_oe   <= driving && en_s;
         drive_active <= state_next == haptic_pkg::DRV_DRIVE;
      end
   end

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_shutdown_quiet: assert property (
      !en_s |=> !out_pos_oe && !out_neg_oe && !out_pos && !out_neg)
      else $error("outputs driven while disabled");

   a_start_delay: assert property (
      $rose(driving) |-> $past(start_cnt_reg) == START_LAST && $past(en_s))
      else $error("drive began before start-up time");

   a_start_silent: assert property (
      state_reg == haptic_pkg::DRV_START |=> !out_pos && !out_neg)
      else $error("drive during start-up");

   a_lin_dead_band: assert property (
      cmd_reg <= haptic_pkg::DUTY_HALF |-> lin_target == 8'h00)
      else $error("linear target not zero at or below half duty");

   a_lin_full_scale: assert property (
      cmd_reg == haptic_pkg::DUTY_FULL |-> lin_target == 8'hfe)
      else $error("linear target not full at full duty");

   a_rot_mid_zero: assert property (
      !mode_lin_reg && cmd_reg == haptic_pkg::DUTY_HALF |-> mag_sel == 8'h00)
      else $error("rotating drive not zero at half duty");

   a_rot_reverse: assert property (
      !mode_lin_reg && driving && cmd_reg == 8'h00 |-> mag_sel == 8'hff && !pos_sel)
      else $error("rotating drive not full reverse at zero duty");

   a_commute_window: assert property (
      commute |-> half_cnt_reg >= HALF_LO && half_cnt_reg <= HALF_HI)
      else $error("commutation outside resonance range");

   a_phase_flip: assert property (
      commute |=> phase_reg != $past(phase_reg) && half_cnt_reg == '0)
      else $error("commutation did not flip phase");

   a_raise_drive: assert property (
      commute && lin_target != 8'h00 && bemf_level < lin_target && amp_reg != 8'hff
      |=> amp_reg > $past(amp_reg) && !brake_reg)
      else $error("drive not raised on low back-EMF");

   a_brake_engage: assert property (
      commute && lin_target != 8'h00 && bemf_level > lin_target |=> brake_reg)
      else $error("brake not engaged on high back-EMF");

   a_brake_hold: assert property (
      lin_on && brake_reg && lin_target == 8'h00 && !commute && en_s |=> brake_reg)
      else $error("brake released while still moving");

   a_idle_on_disable: assert property (
      !en_s |=> ##1 amp_reg == 8'h00 && !brake_reg && !phase_reg)
      else $error("loop state not idle after disable");

endmodule

`default_nettype wire

//--- dv/host_pwm_model.sv
// Host side model: duty PWM source and actuator back-EMF zero crossings.
// Assumes the bench sets high time and period in sys_clk cycles.
`default_nettype none

module host_pwm_model (
   // Clock
   input  wire logic        sys_clk,
   // Settings
   input  wire logic [15:0] high_cyc,
   input  wire logic [15:0] per_cyc,
   // Pins
   output logic             duty_pwm,
   output logic             bemf_polarity
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt_reg  = 16'h0000;
   logic [8:0]  bemf_reg = 9'h000;
   logic        pwm_reg  = 1'b0;
   logic        pol_reg  = 1'b0;
   assign duty_pwm      = pwm_reg;
   assign bemf_polarity = pol_reg;
   // Period of 1000 cycles is 250 kHz, inside the host range
   always @(posedge sys_clk) begin
      cnt_reg  <= (cnt_reg + 16'h0001 >= per_cyc) ? 16'h0000 : cnt_reg + 16'h0001;
      pwm_reg  <= (cnt_reg < high_cyc);
      // Crossing every 300 cycles sits between the scaled half-cycle limits
      bemf_reg <= (bemf_reg == 9'h12b) ? 9'h000 : bemf_reg + 9'h001;
      if (bemf_reg == 9'h12b) begin
         pol_reg <= ~pol_reg;
      end
   end
endmodule

`default_nettype wire

//--- dv/test_haptic_duty_to_drive_control.sv
// Self-checking bench for the haptic duty-to-drive control.
// Assumes scaled counts: start 40, carrier 64, timeout 2000, half cycle 200..400.
`default_nettype none

module test_haptic_duty_to_drive_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 1'b0, rst = 1'b1, drive_enable = 1'b0, actuator_type_select = 1'b0;
   logic [7:0]  supply_code = 8'h90, bemf_level = 8'h00;
   logic [15:0] high_cyc = 16'h0000, per_cyc = 16'h03e8;
   logic        duty_pwm, bemf_polarity, out_pos, out_pos_oe, out_neg, out_neg_oe, drive_active;
   int          err_count = 0, samples_checked = 0, cyc = 0, np, nn;

   always #2 sys_clk = ~sys_clk;

   host_pwm_model u_host_pwm_model (.sys_clk(sys_clk), .high_cyc(high_cyc), .per_cyc(per_cyc),
      .duty_pwm(duty_pwm), .bemf_polarity(bemf_polarity));

   haptic_duty_to_drive_control #(.START_CYC(40), .CARRIER_CYC(64), .PWM_TIMEOUT(2000),
      .HALF_MIN(200), .HALF_MAX(400)) u_haptic_duty_to_drive_control (.sys_clk(sys_clk),
      .rst(rst), .drive_enable(drive_enable), .duty_pwm(duty_pwm),
      .actuator_type_select(actuator_type_select), .supply_code(supply_code),
      .bemf_polarity(bemf_polarity), .bemf_level(bemf_level), .out_pos(out_pos),
      .out_pos_oe(out_pos_oe), .out_neg(out_neg), .out_neg_oe(out_neg_oe),
      .drive_active(drive_active));

   task automatic wrap_up();
      if (err_count == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // Counts driven on-time of each output over n cycles
   task automatic count_on(input int n);
      np = 0;
      nn = 0;
      repeat (n) begin
         @(posedge sys_clk);
         #1;
         np += int'(out_pos === 1'b1 && out_pos_oe === 1'b1);
         nn += int'(out_neg === 1'b1 && out_neg_oe === 1'b1);
      end
   endtask

   task automatic set_drive(input logic [15:0] hi, input logic [7:0] sup, input logic [7:0] bl);
      @(posedge sys_clk);
      high_cyc    <= hi;
      supply_code <= sup;
      bemf_level  <= bl;
   endtask

   // Shutdown, select the mode, enable and time the start
   task automatic start(input logic lin_mode);
      int n;
      n = 0;
      @(posedge sys_clk);
      drive_enable <= 1'b0;
      wait_cyc(8);
      chk("oe_off", 32'h0, 32'({out_pos_oe, out_neg_oe, drive_active}));
      chk("oe_off", 32'h0, 32'({out_pos_oe, out_neg_oe, drive_active}));
      actuator_type_select <= lin_mode;
      wait_cyc(4);
      drive_enable <= 1'b1;
      while (drive_active !== 1'b1 && n < 200) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      chk("start_cycles", 32'h1, 32'(n >= 40 && n <= 45));
      chk("oe_early", 32'h0, {31'h0, out_pos_oe});
      @(posedge sys_clk);
      #1;
      chk("oe_on", 32'h3, {30'h0, out_pos_oe, out_neg_oe});
   endtask

   task automatic rot_case(input logic [15:0] hi, input logic [7:0] sup, input int ep, input int en);
      set_drive(hi, sup, 8'h00);
      wait_cyc(4000);
      count_on(64);
      chk("rot_pos_on", 32'(ep), 32'(np));
      chk("rot_neg_on", 32'(en), 32'(nn));
   endtask

   task automatic t_rotating();
      start(1'b0);
      rot_case(16'h03e8, 8'h90, 63, 0);
      rot_case(16'h02ee, 8'h90, 32, 0);
      rot_case(16'h01f4, 8'h90, 0, 0);
      rot_case(16'h0000, 8'h90, 0, 63);
      rot_case(16'h02ee, 8'hc0, 24, 0);
      rot_case(16'h02ee, 8'h90, 32, 0);
   endtask

   task automatic t_linear();
      start(1'b1);
      set_drive(16'h01f4, 8'h90, 8'h00);
      wait_cyc(4000);
      count_on(1200);
      chk("lin_half_duty", 32'h0, 32'(np + nn));
      set_drive(16'h03e8, 8'h90, 8'h00);
      wait_cyc(4000);
      count_on(1200);
      chk("lin_rise_pos", 32'h1, 32'(np > 0));
      chk("lin_alt_neg", 32'h1, 32'(nn > 0));
      set_drive(16'h0000, 8'h90, 8'h40);
      wait_cyc(4000);
      count_on(1200);
      chk("lin_brake", 32'h1, 32'(np + nn > 0));
      // Steady PWM level is only measured after the edge timeout
      set_drive(16'h03e8, 8'h90, 8'hff);
      wait_cyc(3000);
      count_on(1200);
      chk("lin_over_brake", 32'h1, 32'(np + nn > 0));
      set_drive(16'h0000, 8'h90, 8'h00);
      wait_cyc(3000);
      count_on(1200);
      chk("lin_stopped", 32'h0, 32'(np + nn));
   endtask

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_count++;
         wrap_up();
      end
   end

   initial begin
      wait_cyc(2);
      rst <= 1'b0;
      wait_cyc(50);
      chk("shutdown_oe", 32'h0, 32'({out_pos_oe, out_neg_oe}));
      t_rotating();
      t_linear();
      wrap_up();
   end
endmodule

`default_nettype wire
